// ---- design/jpa_device.sv ----
// device end: test access controller with programming entry gating
`timescale 1ns/1ps
// Operation
// - programmer needs only the four test wires
// - port usable only with fuse and bit clear
// - enable fuse programmed by default
// - reset low clears disable bit after two
// - reset re-enable unsuited for scan or debug
// - test clock slower than chip maximum
// - all shift registers move lsb first
// - four-bit instruction register, sixteen opcodes
// - opcode selects the data register path
// - idle state strobes internal programming clock
module jpa_device (
   input  wire logic core_clk,
   input  wire logic rst,
   jpa_link_if.device link,
   input  wire logic ext_reset_n,
   input  wire logic disable_set,
   input  wire logic [14:0] cmd_result,
   output logic      port_usable,
   output logic      test_port_disable_bit,
   output logic      prog_mode,
   output logic      core_reset_hold,
   output logic [14:0] cmd_word,
   output logic      cmd_strobe,
   output logic      prog_clk_pulse
);
   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   // three stages; a level counts once stages two and three agree
   logic [2:0] tck_s_r, tms_s_r, tdi_s_r, rstn_s_r;
   logic [2:0] tck_s_nxt, tms_s_nxt, tdi_s_nxt, rstn_s_nxt;
   logic       tck_q_r, tms_q_r, tdi_q_r, rstn_q_r;
   logic       tck_q_nxt, tms_q_nxt, tdi_q_nxt, rstn_q_nxt;
   always_comb begin
      tck_s_nxt  = {tck_s_r[1:0], link.tck};
      tms_s_nxt  = {tms_s_r[1:0], link.tms};
      tdi_s_nxt  = {tdi_s_r[1:0], link.tdi};
      rstn_s_nxt = {rstn_s_r[1:0], ext_reset_n};
      tck_q_nxt  = (tck_s_r[1] == tck_s_r[2]) ? tck_s_r[2] : tck_q_r;
      tms_q_nxt  = (tms_s_r[1] == tms_s_r[2]) ? tms_s_r[2] : tms_q_r;
      tdi_q_nxt  = (tdi_s_r[1] == tdi_s_r[2]) ? tdi_s_r[2] : tdi_q_r;
      rstn_q_nxt = (rstn_s_r[1] == rstn_s_r[2]) ? rstn_s_r[2] : rstn_q_r;
   end
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         tck_s_r  <= 3'h0;
         tms_s_r  <= 3'h7;
         tdi_s_r  <= 3'h0;
         rstn_s_r <= 3'h7;
         tck_q_r  <= 1'b0;
         tms_q_r  <= 1'b1;
         tdi_q_r  <= 1'b0;
         rstn_q_r <= 1'b1;
      end else begin
         tck_s_r  <= tck_s_nxt;
         tms_s_r  <= tms_s_nxt;
         tdi_s_r  <= tdi_s_nxt;
         rstn_s_r <= rstn_s_nxt;
         tck_q_r  <= tck_q_nxt;
         tms_q_r  <= tms_q_nxt;
         tdi_q_r  <= tdi_q_nxt;
         rstn_q_r <= rstn_q_nxt;
      end
   end
   wire tck_rise = tck_q_nxt & ~tck_q_r;
   wire tck_fall = ~tck_q_nxt & tck_q_r;

   // ----------------------------------------------------------------
   // enable gating: fuse and disable bit
   // ----------------------------------------------------------------
   // fuse is a constant programmed value; no write path exists here
   logic       test_port_enable_fuse;
   logic       dis_r, dis_nxt;
   logic [1:0] low_cnt_r, low_cnt_nxt;
   assign test_port_enable_fuse = jpa_pkg::FUSE_RESET;
   always_comb begin
      dis_nxt     = dis_r;
      low_cnt_nxt = 2'h0;
      if (!rstn_q_r && dis_r) begin
         low_cnt_nxt = low_cnt_r + 2'h1;
         // clearing wins while the bit is set; once clear, a set is taken even with reset low
         if (low_cnt_r == 2'(jpa_pkg::DIS_CLR_CYC - 1))
            dis_nxt = 1'b0;
      end else if (disable_set) begin
         dis_nxt = 1'b1;
      end
   end
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         dis_r     <= jpa_pkg::DIS_RESET;
         low_cnt_r <= 2'h0;
      end else begin
         dis_r     <= dis_nxt;
         low_cnt_r <= low_cnt_nxt;
      end
   end
   wire usable = test_port_enable_fuse & ~dis_r;

   // ----------------------------------------------------------------
   // access controller and shift paths
   // ----------------------------------------------------------------
   jpa_pkg::jpa_tap_t     st_r, st_nxt;
   logic [3:0]            ir_r, ir_nxt, irs_r, irs_nxt;
   logic [31:0]           dr_r, dr_nxt;
   logic [14:0]           cmd_r, cmd_nxt;
   logic                  pm_r, pm_nxt, rh_r, rh_nxt;
   logic                  tdo_r, tdo_nxt, oe_n_r, oe_n_nxt;
   logic                  stb_r, stb_nxt, pclk_r, pclk_nxt;
   // serial length of the path picked by the opcode
   function automatic int dr_len(input logic [3:0] op);
      unique case (op)
         jpa_pkg::OP_IDCODE:     dr_len = jpa_pkg::ID_W;
         jpa_pkg::OP_PROG_EN:    dr_len = jpa_pkg::EN_W;
         jpa_pkg::OP_PROG_CMD:   dr_len = jpa_pkg::CMD_W;
         default:                dr_len = 1;
      endcase
   endfunction
   always_comb begin
      st_nxt   = st_r;
      ir_nxt   = ir_r;
      irs_nxt  = irs_r;
      dr_nxt   = dr_r;
      cmd_nxt  = cmd_r;
      pm_nxt   = pm_r;
      rh_nxt   = rh_r;
      tdo_nxt  = tdo_r;
      oe_n_nxt = oe_n_r;
      stb_nxt  = 1'b0;
      pclk_nxt = 1'b0;
      if (!usable) begin
         // pins go back to port use; controller held in reset
         // scan state is lost here, so scan or debug cannot lean on the
         // reset re-enable and must keep the pins dedicated
         st_nxt   = jpa_pkg::TS_RESET;
         ir_nxt   = jpa_pkg::IR_RESET_VAL;
         pm_nxt   = 1'b0;
         rh_nxt   = 1'b0;
         oe_n_nxt = 1'b1;
      end else if (tck_rise) begin
         st_nxt = jpa_pkg::tap_next(st_r, tms_q_r);
         unique case (st_r)
            jpa_pkg::TS_RESET: begin
               ir_nxt = jpa_pkg::IR_RESET_VAL;
               pm_nxt = 1'b0;
            end
            jpa_pkg::TS_IDLE:
               pclk_nxt = pm_r;
            jpa_pkg::TS_CAP_IR: irs_nxt = 4'h1;
            jpa_pkg::TS_SH_IR:
               irs_nxt = {tdi_q_r, irs_r[3:1]};
            jpa_pkg::TS_UP_IR: ir_nxt = irs_r;
            jpa_pkg::TS_CAP_DR: begin
               unique case (ir_r)
                  jpa_pkg::OP_IDCODE:   dr_nxt = jpa_pkg::ID_CODE;
                  jpa_pkg::OP_PROG_CMD: dr_nxt = {17'h0_0000, cmd_result};
                  jpa_pkg::OP_CORE_RESET: dr_nxt = {31'h0000_0000, rh_r};
                  default:              dr_nxt = 32'h0000_0000;
               endcase
            end
            jpa_pkg::TS_SH_DR: begin
               // lsb out first; new bit enters at the path's top
               dr_nxt = dr_r >> 1;
               dr_nxt[dr_len(ir_r) - 1] = tdi_q_r;
            end
            jpa_pkg::TS_UP_DR: begin
               if (ir_r == jpa_pkg::OP_CORE_RESET)
                  rh_nxt = dr_r[0];
               if (ir_r == jpa_pkg::OP_PROG_EN)
                  pm_nxt = (dr_r[15:0] == jpa_pkg::PROG_SIG);
               if (ir_r == jpa_pkg::OP_PROG_CMD && pm_r) begin
                  cmd_nxt = dr_r[14:0];
                  stb_nxt = 1'b1;
               end
            end
            default: ;
         endcase
      end else if (tck_fall) begin
         // data out changes on the falling edge
         oe_n_nxt = !(st_r == jpa_pkg::TS_SH_DR ||
                      st_r == jpa_pkg::TS_SH_IR);
         tdo_nxt  = (st_r == jpa_pkg::TS_SH_IR) ? irs_r[0] : dr_r[0];
      end
   end
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         st_r   <= jpa_pkg::TS_RESET;
         ir_r   <= jpa_pkg::IR_RESET_VAL;
         irs_r  <= 4'h0;
         dr_r   <= 32'h0000_0000;
         cmd_r  <= 15'h0000;
         pm_r   <= 1'b0;
         rh_r   <= 1'b0;
         tdo_r  <= 1'b0;
         oe_n_r <= 1'b1;
         stb_r  <= 1'b0;
         pclk_r <= 1'b0;
      end else begin
         st_r   <= st_nxt;
         ir_r   <= ir_nxt;
         irs_r  <= irs_nxt;
         dr_r   <= dr_nxt;
         cmd_r  <= cmd_nxt;
         pm_r   <= pm_nxt;
         rh_r   <= rh_nxt;
         tdo_r  <= tdo_nxt;
         oe_n_r <= oe_n_nxt;
         stb_r  <= stb_nxt;
         pclk_r <= pclk_nxt;
      end
   end
   // usable is combinational from flops; register it for the port
   logic use_r;
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) use_r <= 1'b0;
      else     use_r <= usable;
   end
   assign port_usable           = use_r;
   assign test_port_disable_bit = dis_r;
   assign prog_mode             = pm_r;
   assign core_reset_hold       = rh_r;
   assign cmd_word              = cmd_r;
   assign cmd_strobe            = stb_r;
   assign prog_clk_pulse        = pclk_r;
   assign link.tdo              = tdo_r;
   assign link.tdo_oe_n         = oe_n_r;
endmodule

// ---- design/jpa_host.sv ----
// host end: programmer that drives three of the four test wires and reads tdo
`timescale 1ns/1ps
module jpa_host (
   input  wire logic        core_clk,
   input  wire logic        rst,
   jpa_link_if.host          link,
   input  wire logic        req_valid,
   input  wire logic        req_ir,
   input  wire logic [5:0]  req_len,
   input  wire logic [31:0] req_data,
   input  wire logic [3:0]  req_idle,
   output logic             req_ready,
   output logic             rsp_valid,
   output logic [31:0]      rsp_data
);
   typedef enum logic [2:0] {
      HS_IDLE, HS_NAV, HS_SHIFT, HS_EXIT, HS_RTI
   } jpa_hst_t;
   // ----------------------------------------------------------------
   // tdo synchroniser
   // ----------------------------------------------------------------
   logic [2:0] tdo_s_r, tdo_s_nxt;
   logic       tdo_q_r, tdo_q_nxt;
   always_comb begin
      tdo_s_nxt = {tdo_s_r[1:0], link.tdo};
      tdo_q_nxt = (tdo_s_r[1] == tdo_s_r[2]) ? tdo_s_r[2] : tdo_q_r;
   end
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         tdo_s_r <= 3'h0;
         tdo_q_r <= 1'b0;
      end else begin
         tdo_s_r <= tdo_s_nxt;
         tdo_q_r <= tdo_q_nxt;
      end
   end
   // ----------------------------------------------------------------
   // sequencer: divider-made test clock, tms/tdi set while clock low
   // ----------------------------------------------------------------
   // divider keeps tck far below the chip limit
   jpa_hst_t    st_r, st_nxt;
   logic [2:0]  div_r, div_nxt;
   logic        tck_r, tck_nxt, tms_r, tms_nxt, tdi_r, tdi_nxt;
   logic [2:0]  nav_r, nav_nxt;
   logic [5:0]  cnt_r, cnt_nxt;
   logic [31:0] sh_r, sh_nxt, cap_r, cap_nxt;
   logic        ir_r, ir_nxt, rv_r, rv_nxt, rdy_r, rdy_nxt;
   logic [3:0]  idl_r, idl_nxt;
   logic [5:0]  len_r, len_nxt;
   wire half = (div_r == 3'(jpa_pkg::TCK_HALF - 1));
   wire fall = half & tck_r;
   always_comb begin
      st_nxt  = st_r;
      div_nxt = half ? 3'h0 : div_r + 3'h1;
      tck_nxt = half ? ~tck_r : tck_r;
      tms_nxt = tms_r;
      tdi_nxt = tdi_r;
      nav_nxt = nav_r;
      cnt_nxt = cnt_r;
      sh_nxt  = sh_r;
      cap_nxt = cap_r;
      ir_nxt  = ir_r;
      idl_nxt = idl_r;
      len_nxt = len_r;
      rv_nxt  = 1'b0;
      rdy_nxt = rdy_r;
      unique case (st_r)
         HS_IDLE: if (req_valid && rdy_r) begin
            rdy_nxt = 1'b0;
            sh_nxt  = req_data;
            ir_nxt  = req_ir;
            len_nxt = req_len;
            idl_nxt = req_idle;
            cnt_nxt = 6'h0;
            cap_nxt = 32'h0000_0000;
            nav_nxt = 3'h0;
            st_nxt  = HS_NAV;
         end
         // from idle: 1 (sel-dr), [1 sel-ir], 0 capture, 0 shift
         HS_NAV: if (fall) begin
            nav_nxt = nav_r + 3'h1;
            tms_nxt = (nav_r == 3'h0) || (ir_r && nav_r == 3'h1);
            if (nav_r == (ir_r ? 3'h3 : 3'h2)) begin
               st_nxt  = HS_SHIFT;
               tdi_nxt = sh_r[0];
            end
         end
         HS_SHIFT: if (fall) begin
            // sample what the device put out at the rise before the last one
            if (cnt_r != 6'h0)
               cap_nxt = {tdo_q_r, cap_r[31:1]};
            cnt_nxt = cnt_r + 6'h1;
            sh_nxt  = sh_r >> 1;
            // bit cnt goes out now; the next rise shifts it in
            tdi_nxt = sh_r[0];
            // last bit leaves shift together with tms high
            tms_nxt = (cnt_r == len_r - 6'h1);
            if (cnt_r == len_r - 6'h1)
               st_nxt = HS_EXIT;
         end
         HS_EXIT: if (fall) begin
            // exit1 -> update -> idle
            cap_nxt = {tdo_q_r, cap_r[31:1]};
            tms_nxt = (nav_r == 3'h7) ? 1'b0 : 1'b1;
            nav_nxt = 3'h7;
            if (nav_r == 3'h7) begin
               cnt_nxt = 6'h0;
               st_nxt  = HS_RTI;
            end
         end
         HS_RTI: if (fall) begin
            // idle clocks drive the device's programming clock
            tms_nxt = 1'b0;
            cnt_nxt = cnt_r + 6'h1;
            if (cnt_r[3:0] == idl_r) begin
               rv_nxt  = 1'b1;
               cap_nxt = cap_r >> (6'd32 - len_r);
               rdy_nxt = 1'b1;
               st_nxt  = HS_IDLE;
            end
         end
         default: st_nxt = HS_IDLE;
      endcase
   end
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         st_r  <= HS_IDLE;
         div_r <= 3'h0;
         tck_r <= 1'b0;
         tms_r <= 1'b0;
         tdi_r <= 1'b0;
         nav_r <= 3'h0;
         cnt_r <= 6'h0;
         sh_r  <= 32'h0000_0000;
         cap_r <= 32'h0000_0000;
         ir_r  <= 1'b0;
         idl_r <= 4'h0;
         len_r <= 6'h0;
         rv_r  <= 1'b0;
         rdy_r <= 1'b1;
      end else begin
         st_r  <= st_nxt;
         div_r <= div_nxt;
         tck_r <= tck_nxt;
         tms_r <= tms_nxt;
         tdi_r <= tdi_nxt;
         nav_r <= nav_nxt;
         cnt_r <= cnt_nxt;
         sh_r  <= sh_nxt;
         cap_r <= cap_nxt;
         ir_r  <= ir_nxt;
         idl_r <= idl_nxt;
         len_r <= len_nxt;
         rv_r  <= rv_nxt;
         rdy_r <= rdy_nxt;
      end
   end
   // only tck, tms and tdi are driven, tdo is read back; no reset or clock pin
   assign link.tck  = tck_r;
   assign link.tms  = tms_r;
   assign link.tdi  = tdi_r;
   assign req_ready = rdy_r;
   assign rsp_valid = rv_r;
   assign rsp_data  = cap_r;
endmodule

// ---- design/jpa_link_if.sv ----
// interface: four test-port wires between programmer and device
`timescale 1ns/1ps
interface jpa_link_if;
   logic tck;
   logic tms;
   logic tdi;
   logic tdo;
   logic tdo_oe_n;
   modport device (input tck, input tms, input tdi,
                   output tdo, output tdo_oe_n);
   modport host   (output tck, output tms, output tdi,
                   input tdo, input tdo_oe_n);
endinterface

// ---- design/jpa_pkg.sv ----
// package: shared constants and types for the programming test port
package jpa_pkg;
   localparam int          IR_W          = 4;
   localparam logic [3:0]  IR_RESET_VAL  = 4'h1;
   localparam logic [3:0]  OP_EXTEST     = 4'h0;
   localparam logic [3:0]  OP_IDCODE     = 4'h1;
   localparam logic [3:0]  OP_CORE_RESET = 4'hC;
   localparam logic [3:0]  OP_PROG_EN    = 4'h4;
   localparam logic [3:0]  OP_PROG_CMD   = 4'h5;
   localparam logic [3:0]  OP_BYPASS     = 4'hF;
   localparam int          DR_W          = 16;
   localparam int          EN_W          = 16;
   localparam int          CMD_W         = 15;
   localparam int          ID_W          = 32;
   // arbitrary neutral identity value
   localparam logic [31:0] ID_CODE       = 32'h1234_5671;
   // programming enable signature, arbitrary
   localparam logic [15:0] PROG_SIG      = 16'hA370;
   localparam logic        FUSE_RESET    = 1'b1;
   localparam logic        DIS_RESET     = 1'b0;
   localparam int          DIS_CLR_CYC   = 2;
   // host divider: test clock period = 2*TCK_HALF core cycles
   localparam int          TCK_HALF      = 4;
   typedef enum logic [3:0] {
      TS_RESET, TS_IDLE, TS_SEL_DR, TS_CAP_DR, TS_SH_DR, TS_EX1_DR,
      TS_PA_DR, TS_EX2_DR, TS_UP_DR, TS_SEL_IR, TS_CAP_IR, TS_SH_IR,
      TS_EX1_IR, TS_PA_IR, TS_EX2_IR, TS_UP_IR
   } jpa_tap_t;
   // standard next-state function of the access controller
   function automatic jpa_tap_t tap_next(input jpa_tap_t s,
                                          input logic mode);
      unique case (s)
         TS_RESET:  tap_next = mode ? TS_RESET  : TS_IDLE;
         TS_IDLE:   tap_next = mode ? TS_SEL_DR : TS_IDLE;
         TS_SEL_DR: tap_next = mode ? TS_SEL_IR : TS_CAP_DR;
         TS_CAP_DR: tap_next = mode ? TS_EX1_DR : TS_SH_DR;
         TS_SH_DR:  tap_next = mode ? TS_EX1_DR : TS_SH_DR;
         TS_EX1_DR: tap_next = mode ? TS_UP_DR  : TS_PA_DR;
         TS_PA_DR:  tap_next = mode ? TS_EX2_DR : TS_PA_DR;
         TS_EX2_DR: tap_next = mode ? TS_UP_DR  : TS_SH_DR;
         TS_UP_DR:  tap_next = mode ? TS_SEL_DR : TS_IDLE;
         TS_SEL_IR: tap_next = mode ? TS_RESET  : TS_CAP_IR;
         TS_CAP_IR: tap_next = mode ? TS_EX1_IR : TS_SH_IR;
         TS_SH_IR:  tap_next = mode ? TS_EX1_IR : TS_SH_IR;
         TS_EX1_IR: tap_next = mode ? TS_UP_IR  : TS_PA_IR;
         TS_PA_IR:  tap_next = mode ? TS_EX2_IR : TS_PA_IR;
         TS_EX2_IR: tap_next = mode ? TS_UP_IR  : TS_SH_IR;
         TS_UP_IR:  tap_next = mode ? TS_SEL_DR : TS_IDLE;
      endcase
   endfunction
endpackage

// ---- tb/jpa_checker.sv ----
// checker: timing relations watched on the four test-port wires
`timescale 1ns/1ps
module jpa_checker (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   input wire logic tdo,
   input wire logic tdo_oe_n
);
   // ---------------------------------------------------------------
   // link timing properties
   // ---------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   // mode select moves only while the test clock is low
   property p_tms_low; $changed(tms) |-> !tck; endproperty
   a_tms_low: assert property (p_tms_low)
      else $error("tms changed while tck high");

   // mode select holds over the whole high phase
   property p_tms_hold; $rose(tck) |=> $stable(tms) [*3]; endproperty
   a_tms_hold: assert property (p_tms_hold)
      else $error("tms moved during tck high phase");

   // serial data in moves only while the test clock is low
   property p_tdi_low; $changed(tdi) |-> !tck; endproperty
   a_tdi_low: assert property (p_tdi_low)
      else $error("tdi changed while tck high");

   // data out is launched on falling test clock edges only; the device
   // sees the fall half a period late, so the low phase is looked at
   property p_tdo_low;
      $changed(tdo) && !tdo_oe_n |-> !$past(tck);
   endproperty
   a_tdo_low: assert property (p_tdo_low)
      else $error("tdo changed while tck high");

   // the drive enable follows the shift states, so it moves on falls
   property p_oe_low; $changed(tdo_oe_n) |-> !$past(tck); endproperty
   a_oe_low: assert property (p_oe_low)
      else $error("tdo_oe_n changed while tck high");

   // the test clock stays far below the core rate: high four cycles
   property p_tck_high; $rose(tck) |-> tck [*4] ##1 !tck; endproperty
   a_tck_high: assert property (p_tck_high)
      else $error("tck high phase not four cycles");

   // low phase lasts four cycles, between frames as well; the divider never stops
   property p_tck_lowp; $fell(tck) |-> (!tck) [*4]; endproperty
   a_tck_lowp: assert property (p_tck_lowp)
      else $error("tck low phase too short");

   // a shift state lasts at least one whole test clock period
   property p_oe_span; $fell(tdo_oe_n) |-> (!tdo_oe_n) [*8]; endproperty
   a_oe_span: assert property (p_oe_span)
      else $error("tdo drive window shorter than one tck period");
endmodule

// ---- tb/test_jtag_programming_access.sv ----
// testbench: host and device ends joined over the test-port link
`timescale 1ns/1ps
`define CMP(got, exp) begin compares++; if ((got) !== (exp)) begin \
   mismatches++; $display("[ERR] %0t got %h exp %h", $time, got, exp); \
   end end
module test_jtag_programming_access;
   logic        core_clk;
   logic        rst;
   logic        ext_reset_n;
   logic        disable_set;
   logic [14:0] cmd_result;
   logic        port_usable;
   logic        test_port_disable_bit;
   logic        prog_mode;
   logic        core_reset_hold;
   logic [14:0] cmd_word;
   logic        cmd_strobe;
   logic        prog_clk_pulse;
   logic        req_valid;
   logic        req_ir;
   logic [5:0]  req_len;
   logic [31:0] req_data;
   logic [3:0]  req_idle;
   logic        req_ready;
   logic        rsp_valid;
   logic [31:0] rsp_data;
   logic [31:0] seed;
   logic [31:0] got;
   int          mismatches;
   int          compares;
   int          cycles;
   int          n_strobe;
   int          n_pclk;

   // ---------------------------------------------------------------
   // structure: both ends face each other over one link
   // ---------------------------------------------------------------
   jpa_link_if i_jpa_link_if ();
   jpa_device i_jpa_device (.core_clk, .rst, .link(i_jpa_link_if),
      .ext_reset_n, .disable_set, .cmd_result, .port_usable,
      .test_port_disable_bit, .prog_mode, .core_reset_hold, .cmd_word,
      .cmd_strobe, .prog_clk_pulse);
   jpa_host i_jpa_host (.core_clk, .rst, .link(i_jpa_link_if), .req_valid,
      .req_ir, .req_len, .req_data, .req_idle, .req_ready, .rsp_valid,
      .rsp_data);
   jpa_checker i_jpa_checker (.core_clk, .rst, .tck(i_jpa_link_if.tck),
      .tms(i_jpa_link_if.tms), .tdi(i_jpa_link_if.tdi),
      .tdo(i_jpa_link_if.tdo), .tdo_oe_n(i_jpa_link_if.tdo_oe_n));

   // 200 MHz core clock
   always #2.5 core_clk = ~core_clk;

   // pulse counters sampled mid-cycle; cycle ceiling cuts a hang short
   always @(negedge core_clk) begin
      cycles++;
      if (cmd_strobe === 1'b1) n_strobe++;
      if (prog_clk_pulse === 1'b1) n_pclk++;
      if (cycles == 60000) begin
         mismatches++;
         finish_test();
      end
   end

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      s = s ^ (s << 5);
      return s;
   endfunction

   // mask of the captured bits, right aligned
   function automatic logic [31:0] lmask(input logic [5:0] n);
      return (n >= 6'd32) ? 32'hffff_ffff : (32'h0000_0001 << n) - 1;
   endfunction

   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask

   // one scan: valid is raised only once ready is seen, so it is taken
   task automatic scan(input logic ir, input logic [5:0] len,
         input logic [31:0] d, input logic [3:0] idle);
      int k;
      k = 0;
      while (req_ready !== 1'b1 && k < 1000) begin
         tick(1);
         k++;
      end
      req_ir = ir;
      req_len = len;
      req_data = d;
      req_idle = idle;
      req_valid = 1'b1;
      tick(1);
      req_valid = 1'b0;
      k = 0;
      while (rsp_valid !== 1'b1 && k < 3000) begin
         tick(1);
         k++;
      end
      `CMP(rsp_valid, 1'b1)
      got = rsp_data;
   endtask

   task automatic load_ir(input logic [3:0] op);
      scan(1'b1, 6'd4, {28'h000_0000, op}, 4'h0);
   endtask

   // the free-running test clock with tms low walks the controller out of reset before this scan
   task automatic id_check();
      load_ir(jpa_pkg::OP_IDCODE);
      seed = xs(seed);
      scan(1'b0, 6'd32, seed, 4'h1);
      `CMP(got, jpa_pkg::ID_CODE)
   endtask

   task automatic finish_test();
      if (mismatches == 0 && compares > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      int          i;
      int          k0;
      int          p0;
      logic [5:0]  len;
      logic [31:0] d;
      core_clk = 0;
      rst = 1;
      ext_reset_n = 1;
      disable_set = 0;
      cmd_result = 15'h0000;
      req_valid = 0;
      req_ir = 0;
      req_len = 6'h00;
      req_data = 32'h0000_0000;
      req_idle = 4'h0;
      seed = 32'hb38b_8774;
      tick(5);
      rst = 0;
      tick(2);
      `CMP(port_usable, 1'b1)
      `CMP(test_port_disable_bit, jpa_pkg::DIS_RESET)
      `CMP(req_ready, 1'b1)
      id_check();
      // bypass: one capture zero, then data delayed by one bit
      load_ir(jpa_pkg::OP_BYPASS);
      for (i = 0; i < 6; i++) begin
         seed = xs(seed);
         len = (i == 0) ? 6'd1 : (i == 1) ? 6'd32 : {1'b0, seed[4:0]} + 6'd1;
         d = xs(seed);
         scan(1'b0, len, d, 4'h0);
         `CMP(got, (d << 1) & lmask(len))
      end
      // wrong signature first, then the right one
      load_ir(jpa_pkg::OP_PROG_EN);
      scan(1'b0, 6'd16,
         {16'h0000, jpa_pkg::PROG_SIG ^ (seed[15:0] | 16'h0001)}, 4'h0);
      tick(2);
      `CMP(prog_mode, 1'b0)
      scan(1'b0, 6'd16, {16'h0000, jpa_pkg::PROG_SIG}, 4'h0);
      tick(2);
      `CMP(prog_mode, 1'b1)
      // back-to-back commands with idle clocks after each
      load_ir(jpa_pkg::OP_PROG_CMD);
      for (i = 0; i < 3; i++) begin
         seed = xs(seed);
         cmd_result = seed[14:0];
         seed = xs(seed);
         k0 = n_strobe;
         p0 = n_pclk;
         scan(1'b0, 6'd15, {17'h0_0000, seed[14:0]}, 4'h3);
         tick(2);
         `CMP(got, {17'h0_0000, cmd_result})
         `CMP(cmd_word, seed[14:0])
         `CMP(n_strobe - k0, 1)
         `CMP((n_pclk - p0) >= 3, 1'b1)
      end
      // one-bit reset chain
      load_ir(jpa_pkg::OP_CORE_RESET);
      scan(1'b0, 6'd1, 32'h0000_0001, 4'h0);
      tick(2);
      `CMP(core_reset_hold, 1'b1)
      scan(1'b0, 6'd1, 32'h0000_0000, 4'h0);
      tick(2);
      `CMP(core_reset_hold, 1'b0)
      // disable, then win the port back by holding external reset low
      disable_set = 1;
      tick(1);
      disable_set = 0;
      tick(4);
      `CMP(test_port_disable_bit, 1'b1)
      `CMP(port_usable, 1'b0)
      ext_reset_n = 0;
      tick(2);
      `CMP(test_port_disable_bit, 1'b1)
      tick(8);
      `CMP(test_port_disable_bit, 1'b0)
      `CMP(port_usable, 1'b1)
      disable_set = 1;
      tick(2);
      disable_set = 0;
      tick(1);
      `CMP(test_port_disable_bit, 1'b0)
      ext_reset_n = 1;
      tick(4);
      // second reset in mid-run, then the port works again
      rst = 1;
      tick(5);
      rst = 0;
      tick(2);
      id_check();
      finish_test();
   end
endmodule
